// [cbwp_map.svh]
// Constants for the coprocessor busy-wait and privilege handshake.
// Assumes both ends share one clock and a synchronous active-high reset.
// Summary of operation
// - Coprocessor gates privileged instructions on privilege output
// - Non-move mode change updates privilege after execute one
// - Status move updates privilege after second execute cycle
// - Only decode response at advance into execute counts
// - WAIT on execute handshake loops any cycles
// - Interrupt abandons busy-wait, condition pass driven low
// - Coprocessor samples condition pass each busy-wait cycle
// - Condition pass low abandons instruction entirely
// - Codes ABSENT 10, WAIT 00, GO 01, LAST 11
// - No coprocessor state change before pass and GO/LAST
// - Interrupt-abandoned instruction is restarted later by processor
`ifndef CBWP_MAP_SVH
`define CBWP_MAP_SVH
// ============================================================
// Handshake codes
`define CBWP_HS_ABSENT 2'h2
`define CBWP_HS_WAIT   2'h0
`define CBWP_HS_GO     2'h1
`define CBWP_HS_LAST   2'h3
// ============================================================
// Reset values and instruction width
`define CBWP_PRIV_RST  1'h1
`define CBWP_INSTR_W   8
// ============================================================
// Privilege update delays: extra cycles held after the mode change edge
`define CBWP_PLAIN_DLY 2'h0
`define CBWP_MOVE_DLY  2'h1
`endif

// [cbwp_pkg.sv]
// Types shared by both ends of the coprocessor handshake.
// Assumes cbwp_map.svh is on the include path.
`include "cbwp_map.svh"
package cbwp_pkg;
    // ============================================================
    // Handshake code type
    typedef enum logic [1:0] {
        CBWP_ABSENT = `CBWP_HS_ABSENT,
        CBWP_WAIT   = `CBWP_HS_WAIT,
        CBWP_GO     = `CBWP_HS_GO,
        CBWP_LAST   = `CBWP_HS_LAST
    } cbwp_hs_t;
    typedef logic [`CBWP_INSTR_W-1:0] cbwp_instr_t;
endpackage

// [cbwp_if.sv]
// Link between the processor end and the coprocessor end.
// Assumes both ends run on clk.
`timescale 1ns/1ns
interface cbwp_if (input wire logic clk);
    import cbwp_pkg::*;
    logic        decode_valid;      // Instruction present in Decode
    logic        advance;           // Decode instruction moves to Execute this cycle
    cbwp_instr_t instr;             // Instruction in Decode
    logic        privilege_mode_out; // High in privileged mode
    logic        condition_pass;    // High while instruction in Execute to be done
    cbwp_hs_t    decode_handshake;
    cbwp_hs_t    execute_handshake;
    modport proc (output decode_valid, advance, instr, privilege_mode_out,
                  condition_pass, input decode_handshake, execute_handshake);
    modport copro (input decode_valid, advance, instr, privilege_mode_out,
                   condition_pass, output decode_handshake, execute_handshake);
endinterface // cbwp_if

// [cbwp_proc.sv]
// Processor end: issues instructions, tracks privilege, busy-waits.
// Assumes the coprocessor end answers on the same clock.
`timescale 1ns/1ns
`include "cbwp_map.svh"
module cbwp_proc (
    input  wire logic        clk,
    input  wire logic        rst,
    // Link
    cbwp_if.proc             lnk,
    // Issue side
    input  wire logic        issue_valid,
    input  wire cbwp_pkg::cbwp_instr_t issue_instr,
    input  wire logic        issue_pass,
    input  wire logic        irq,
    // Mode changes
    input  wire logic        mode_change,
    input  wire logic        mode_is_move,
    input  wire logic        mode_priv,
    // Results
    output logic             issue_ready,
    output logic             done_r,
    output logic             undef_r,
    output logic             abandon_r
);
    import cbwp_pkg::*;
    typedef enum logic [1:0] {
        CBWP_IDLE = 2'h0, CBWP_DEC = 2'h1, CBWP_EXE = 2'h2
    } cbwp_pst_t;
    cbwp_pst_t   st_r;
    cbwp_instr_t instr_r, retry_r;
    logic        retry_v_r, pass_r, priv_r, pend_r, pend_priv_r;
    logic [1:0]  pend_cnt_r;

    assign issue_ready          = (st_r == CBWP_IDLE) && !retry_v_r;
    assign lnk.instr            = instr_r;
    assign lnk.decode_valid     = (st_r == CBWP_DEC);
    assign lnk.advance          = (st_r == CBWP_DEC);
    assign lnk.condition_pass   = pass_r;
    assign lnk.privilege_mode_out = priv_r;

    // ============================================================
    // Privilege output, delayed by the execute cycles of the change
    always_ff @(posedge clk) begin
        if (rst) begin
            priv_r     <= `CBWP_PRIV_RST;
            pend_r     <= 1'b0;
            pend_priv_r <= 1'b0;
            pend_cnt_r <= 2'h0;
        end else if (mode_change) begin
            pend_r      <= 1'b1;
            pend_priv_r <= mode_priv;
            pend_cnt_r  <= mode_is_move ? `CBWP_MOVE_DLY : `CBWP_PLAIN_DLY;
        end else if (pend_r) begin
            if (pend_cnt_r == 2'h0) begin
                priv_r <= pend_priv_r;
                pend_r <= 1'b0;
            end else begin
                pend_cnt_r <= pend_cnt_r - 2'h1;
            end
        end
    end

    // ============================================================
    // Pipeline: decode answer sampled only as instruction advances
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r      <= CBWP_IDLE;
            instr_r   <= '0;
            pass_r    <= 1'b0;
            retry_v_r <= 1'b0;
            retry_r   <= '0;
            done_r    <= 1'b0;
            undef_r   <= 1'b0;
            abandon_r <= 1'b0;
        end else begin
            done_r    <= 1'b0;
            undef_r   <= 1'b0;
            abandon_r <= 1'b0;
            case (st_r)
                CBWP_IDLE: begin
                    if (retry_v_r && !irq) begin
                        instr_r   <= retry_r;
                        pass_r    <= 1'b1; // Only a passed instruction is ever abandoned
                        retry_v_r <= 1'b0;
                        st_r      <= CBWP_DEC;
                    end else if (issue_valid && !retry_v_r) begin
                        instr_r <= issue_instr;
                        pass_r  <= issue_pass;
                        st_r    <= CBWP_DEC;
                    end
                end
                CBWP_DEC: begin
                    // Earlier decode answers never reach here: only this one counts.
                    // A failed condition drops the instruction whatever the answer.
                    if (!pass_r) begin
                        st_r <= CBWP_IDLE;
                    end else begin
                        case (lnk.decode_handshake)
                            CBWP_ABSENT: begin undef_r <= 1'b1; st_r <= CBWP_IDLE; end
                            CBWP_LAST, CBWP_GO: begin done_r <= 1'b1; st_r <= CBWP_IDLE; end
                            default: st_r <= CBWP_EXE;
                        endcase
                    end
                end
                CBWP_EXE: begin
                    // Only a true busy-wait is broken; a LAST answer has already committed
                    if (irq && pass_r && lnk.execute_handshake == CBWP_WAIT) begin
                        pass_r    <= 1'b0;
                        abandon_r <= 1'b1;
                        retry_v_r <= 1'b1;
                        retry_r   <= instr_r;
                        st_r      <= CBWP_IDLE;
                    end else begin
                        case (lnk.execute_handshake)
                            CBWP_ABSENT: begin undef_r <= 1'b1; st_r <= CBWP_IDLE; end
                            CBWP_LAST, CBWP_GO: begin done_r <= pass_r; st_r <= CBWP_IDLE; end
                            default: st_r <= CBWP_EXE;
                        endcase
                    end
                end
                default: st_r <= CBWP_IDLE;
            endcase
        end
    end
endmodule // cbwp_proc

// [cbwp_copro.sv]
// Coprocessor end: answers handshakes, gates privileged work.
// Assumes the processor end shares clk.
`timescale 1ns/1ns
module cbwp_copro (
    input  wire logic        clk,
    input  wire logic        rst,
    // Link
    cbwp_if.copro            lnk,
    // Local status
    input  wire logic        busy,
    input  wire logic        priv_only,
    input  wire logic        recognised,
    // Results
    output logic             commit_r,
    output cbwp_pkg::cbwp_instr_t commit_instr_r
);
    import cbwp_pkg::*;
    logic in_exe_r;
    cbwp_instr_t exe_instr_r;
    cbwp_hs_t    ans;

    // ============================================================
    // Answer for the instruction in decode, revised as privilege moves
    always_comb begin
        if (!recognised || (priv_only && !lnk.privilege_mode_out))
            ans = CBWP_ABSENT;
        else if (busy)
            ans = CBWP_WAIT;
        else
            ans = CBWP_LAST;
    end
    assign lnk.decode_handshake  = lnk.decode_valid ? ans : CBWP_ABSENT;
    assign lnk.execute_handshake = !in_exe_r ? CBWP_ABSENT :
                                   busy ? CBWP_WAIT : CBWP_LAST;

    // ============================================================
    // Busy-wait tracking; commit only with pass high and GO/LAST
    always_ff @(posedge clk) begin
        if (rst) begin
            in_exe_r       <= 1'b0;
            exe_instr_r    <= '0;
            commit_r       <= 1'b0;
            commit_instr_r <= '0;
        end else begin
            commit_r <= 1'b0;
            if (lnk.advance && ans == CBWP_WAIT) begin
                in_exe_r    <= 1'b1;
                exe_instr_r <= lnk.instr;
            end else if (lnk.advance && ans == CBWP_LAST && lnk.condition_pass) begin
                commit_r       <= 1'b1;
                commit_instr_r <= lnk.instr;
            end else if (in_exe_r) begin
                if (!lnk.condition_pass) begin
                    in_exe_r <= 1'b0;
                end else if (!busy) begin
                    in_exe_r       <= 1'b0;
                    commit_r       <= 1'b1;
                    commit_instr_r <= exe_instr_r;
                end
            end
        end
    end
endmodule // cbwp_copro

// [cbwp_asserts.sv]
// Checker for the processor-to-coprocessor link signals.
// Assumes one clock and a synchronous active-high reset on both ends.
`timescale 1ns/1ns
`include "cbwp_map.svh"
module cbwp_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic decode_valid,
    input wire logic advance,
    input wire logic privilege_mode_out,
    input wire logic condition_pass,
    input wire logic [1:0] execute_handshake
);
    // ============================================================
    // Link properties, all in the one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    adv_in_decode_a: assert property (advance |-> decode_valid)
        else $error("advance without an instruction in decode");
    wait_hold_a: assert property (execute_handshake == `CBWP_HS_WAIT && condition_pass
        |=> execute_handshake != `CBWP_HS_ABSENT)
        else $error("busy-wait dropped while pass was high");
    busy_abandon_a: assert property (execute_handshake == `CBWP_HS_WAIT && !condition_pass
        |=> execute_handshake == `CBWP_HS_ABSENT)
        else $error("busy-wait kept after pass went low");
    adv_gap_a: assert property (advance |=> !decode_valid)
        else $error("second decode right after advance");
    reset_state_a: assert property ($fell(rst) |-> privilege_mode_out && !condition_pass)
        else $error("link not at reset values");
    pass_rise_a: assert property ($rose(condition_pass) |-> decode_valid)
        else $error("pass rose without an instruction in decode");
    pass_rise_idle_a: assert property ($rose(condition_pass) |-> !$past(decode_valid))
        else $error("pass rose in a second decode cycle");
    priv_settle_a: assert property ($changed(privilege_mode_out) |=> $stable(privilege_mode_out))
        else $error("privilege output toggled twice");
    pass_fall_a: assert property ($fell(condition_pass) && !decode_valid
        |-> $past(execute_handshake == `CBWP_HS_WAIT))
        else $error("pass fell outside a busy-wait");
endmodule // cbwp_asserts

// [tb_top.sv]
// Bench joining the processor end to the coprocessor end.
// Assumes cbwp_pkg, cbwp_if and both ends compiled before it.
`timescale 1ns/1ns
module tb_top;
    import cbwp_pkg::*;
    `define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
        $display("CHECK FAILED at %0t: value mismatch", $time); end end
    // ============================================================
    // Stimulus, results and instances
    logic        clk = 0, rst = 1, iv = 0, ip = 1, irq = 0, mc = 0, mm = 0, mp = 1;
    logic        busy = 0, po = 0, rec = 1, rdy, done, und, abn, com;
    logic        s_done, s_und, s_abn, s_com;
    cbwp_instr_t ins = 8'h00, cins, ci;
    cbwp_hs_t    hs;
    int          error_cnt = 0, checked = 0, cyc = 0, n, m;
    logic [3:0]  rows [5] = '{4'b0011, 4'b0000, 4'b1111, 4'b1010, 4'b1100}; // po,priv,rec,ok
    cbwp_if lnk (.clk(clk));
    cbwp_proc i_cbwp_proc (.clk(clk), .rst(rst), .lnk(lnk), .issue_valid(iv), .issue_instr(ins),
        .issue_pass(ip), .irq(irq), .mode_change(mc), .mode_is_move(mm), .mode_priv(mp),
        .issue_ready(rdy), .done_r(done), .undef_r(und), .abandon_r(abn));
    cbwp_copro i_cbwp_copro (.clk(clk), .rst(rst), .lnk(lnk), .busy(busy), .priv_only(po),
        .recognised(rec), .commit_r(com), .commit_instr_r(cins));
    cbwp_asserts i_cbwp_asserts (.clk(clk), .rst(rst), .decode_valid(lnk.decode_valid),
        .advance(lnk.advance), .privilege_mode_out(lnk.privilege_mode_out),
        .condition_pass(lnk.condition_pass), .execute_handshake(lnk.execute_handshake));
    initial forever #2 clk = ~clk;
    // Catch one-cycle pulses at the falling edge, where they have settled
    always @(negedge clk) begin
        if (done) s_done = 1;
        if (und) s_und = 1;
        if (abn) s_abn = 1;
        if (com) begin s_com = 1; ci = cins; end
        if (lnk.decode_valid) hs = lnk.decode_handshake;
    end
    // A hang ends the run as a failure rather than stalling it
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            test_done();
        end
    end
    task automatic test_done();
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic reset_link();
        rst = 1; repeat (5) @(posedge clk); #1 rst = 0;
        `CHK(lnk.privilege_mode_out, 1'b1)
        `CHK(lnk.condition_pass, 1'b0)
    endtask
    // Issue one instruction, then wait up to w cycles for an outcome
    task automatic op(input cbwp_instr_t i, input int w);
        int k;
        for (k = 0; k < 50 && rdy !== 1'b1; k++) begin @(posedge clk); #1; end
        {s_done, s_und, s_abn, s_com} = 4'h0;
        iv = 1; ins = i;
        @(posedge clk); #1 iv = 0;
        for (k = 0; k < w && !(s_done || s_und || s_abn); k++) @(posedge clk);
        repeat (2) @(posedge clk); #1;
    endtask
    // Count the edges until the privilege output shows the new mode
    task automatic mode(input logic mv, input logic pv, output int c);
        mc = 1; mm = mv; mp = pv;
        @(posedge clk); #1 mc = 0;
        for (c = 0; c < 9 && lnk.privilege_mode_out !== pv; c++) begin @(posedge clk); #1; end
        @(posedge clk); #1;
    endtask
    initial begin
        reset_link();
        mode(1'b0, 1'b0, n); mode(1'b1, 1'b1, m);
        `CHK(n, 1)
        `CHK(m, 2)
        foreach (rows[j]) begin
            po = rows[j][3]; rec = rows[j][1];
            if (lnk.privilege_mode_out !== rows[j][2]) mode(1'b0, rows[j][2], n);
            op(cbwp_instr_t'(8'h10 + j), 20);
            `CHK(s_done, rows[j][0])
            `CHK(s_com, rows[j][0])
            `CHK(hs == CBWP_ABSENT, !rows[j][0])
            `CHK(s_und, !rows[j][0])
        end
        // Busy-wait broken by an interrupt, then restarted
        po = 0; rec = 1; busy = 1; op(8'h5A, 8);
        `CHK({s_done, s_com}, 2'b00)
        `CHK(hs, CBWP_WAIT)
        `CHK(lnk.execute_handshake, CBWP_WAIT)
        `CHK(lnk.condition_pass, 1'b1)
        irq = 1; repeat (3) @(posedge clk); #1;
        `CHK({s_abn, lnk.condition_pass, s_com}, 3'b100)
        `CHK(rdy, 1'b0)
        irq = 0; busy = 0;
        for (n = 0; n < 30 && !s_com; n++) @(posedge clk);
        #1;
        `CHK(s_done & s_com, 1'b1)
        `CHK(ci, 8'h5A)
        // Long wait ended by the coprocessor, then a failed condition
        busy = 1; op(8'h33, 12); busy = 0;
        for (n = 0; n < 30 && !s_com; n++) @(posedge clk);
        #1;
        `CHK({s_abn, ci}, 9'h033)
        ip = 0; op(8'h44, 20); ip = 1;
        `CHK(s_com, 1'b0)
        // Reset in mid busy-wait leaves nothing behind
        busy = 1; op(8'h66, 4); reset_link(); busy = 0;
        repeat (10) @(posedge clk); #1;
        `CHK(s_com, 1'b0)
        test_done();
    end
endmodule // tb_top
